/* dct_consts.vh */
// Purpose: constants for the down-counting timer channels
// Assumes: Wishbone byte addressing, word-aligned byte offsets below
// Notes: definitions only
`ifndef DCT_CONSTS_VH
`define DCT_CONSTS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DCT_OFF_START_LO 8'h00
`define DCT_OFF_START_HI 8'h04
`define DCT_OFF_CAPTURE 8'h08
`define DCT_OFF_CTRL_BASE 8'h10
`define DCT_OFF_CONST_BASE 8'h30
`define DCT_OFF_COUNT_BASE 8'h50
// ----------------------------------------
// Control field positions
// ----------------------------------------
`define DCT_BIT_CAP_FLAG 9
`define DCT_BIT_UNF_FLAG 8
`define DCT_BIT_CAP_HI 7
`define DCT_BIT_CAP_LO 6
`define DCT_BIT_UNF_IE 5
`define DCT_BIT_EDGE_HI 4
`define DCT_BIT_EDGE_LO 3
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define DCT_CNT_RESET 32'hFFFFFFFF
`define DCT_CTRL_RESET 16'h0000
`define DCT_PS_RTC 3'h6
`define DCT_PS_EXT 3'h7
`define DCT_CAP_IRQ_CODE 2'h3
`endif

/* dct_dma_model.sv */
// Purpose: DMA controller stand-in serving capture requests
// Assumes: request stays high until done has been seen
// Notes: slow mode raises done on the 41st cycle of a request
`timescale 1ns/1ps
module dct_dma_model (
  input wire clk_sys,
  input wire reset,
  input wire capture_dma_req,
  input wire slow,
  output reg dma_done
);
  reg [5:0] wait_r; // Cycles spent on current request
  // One pulse of done per request, then idle a cycle so the drop is seen
  always @(posedge clk_sys) begin
    if (reset) begin
      wait_r <= 6'h00;
      dma_done <= 1'b0;
    end else if (dma_done) begin
      wait_r <= 6'h00;
      dma_done <= 1'b0;
    end else if (capture_dma_req) begin
      if (wait_r == (slow ? 6'h28 : 6'h01)) dma_done <= 1'b1;
      else wait_r <= wait_r + 6'h01;
    end
  end
endmodule

/* dct_timer.v */
// Purpose: five-channel 32-bit down counter timer with channel-2 capture
// Assumes: classic Wishbone slave, single clock clk_sys at 50 MHz
// Notes: timer_pin and rtc_clock are asynchronous and synchronised here
//
// What this block does
// RULE1 - Channels 3,4 keep only flag, enable, prescaler
// RULE2 - Reserved control bits read zero, ignore writes
// RULE3 - Capture flag set on capture, write-zero clears
// RULE4 - Underflow flag set on underflow, write-zero clears
// RULE5 - Capture enabled raises DMA request per event
// RULE6 - Capture copies counter only when flag clear
// RULE7 - No new DMA request until previous done
// RULE8 - Capture control: off, reserved, on, on+irq
// RULE9 - Underflow irq needs enable and flag
// RULE10 - Edge field selects rising, falling, both
// RULE11 - Prescaler selects divider, RTC or pin
// RULE12 - Software avoids RTC/pin codes on 3,4
// RULE13 - RTC-clocked channels 0-2 run in standby
// RULE14 - Capture register 32-bit, read-only, never reset
// RULE15 - Each channel: down counter plus reload constant
// RULE16 - Counter runs once its start bit set
// RULE17 - Underflow sets flag and reloads constant together
// RULE18 - Software programs setup before setting start
// RULE19 - Software sets timer pin as input first
// RULE20 - Start bits split over two start registers
// RULE21 - Capture irq needs flag and control 11
// RULE22 - Read during decrement returns pre-decrement value
// RULE23 - Pin and RTC inputs synchronised, edge-detected
// RULE24 - Software counter/constant writes beat decrement
`timescale 1ns/1ps
`include "dct_consts.vh"
module dct_timer (
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire standby,
  input wire timer_pin,
  input wire rtc_clock,
  input wire dma_done,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg [4:0] underflow_irq,
  output reg capture_irq,
  output reg capture_dma_req
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [31:0] down_counter_r [0:4];     // Live counters
  reg [31:0] reload_constant_r [0:4];  // Auto-reload values
  reg [15:0] channel_control_r [0:4];  // Control fields, masked per channel
  reg [2:0] start_register_low_r;      // Run bits ch0-2
  reg [1:0] start_register_high_r;     // Run bits ch3-4
  reg [31:0] capture_value_r;          // Never reset on purpose
  reg [9:0] presc_r;                   // Free divider for Pck/4..1024
  reg [9:0] presc_nxt;
  reg pin_s1_r, pin_s2_r, pin_s3_r;    // Pin synchroniser plus history
  reg rtc_s1_r, rtc_s2_r, rtc_s3_r;    // RTC synchroniser plus history
  reg dma_busy_r;                      // Previous DMA request outstanding
  wire [4:0] run_bits = {start_register_high_r, start_register_low_r};
  wire wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  wire rd_req = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
  wire [15:0] ctl_wdata = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
  // ----------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------
  // Two flops before use; the third only holds history for the edge detector
  always @(posedge clk_sys) begin
    if (reset) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_s3_r <= 1'b0;
      rtc_s1_r <= 1'b0;
      rtc_s2_r <= 1'b0;
      rtc_s3_r <= 1'b0;
    end else if (clk_en) begin
      pin_s1_r <= timer_pin;   // [RULE23]
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      rtc_s1_r <= rtc_clock;   // [RULE23]
      rtc_s2_r <= rtc_s1_r;
      rtc_s3_r <= rtc_s2_r;
    end
  end
  wire pin_rise = pin_s2_r & ~pin_s3_r;  // [RULE23]
  wire pin_fall = ~pin_s2_r & pin_s3_r;
  wire rtc_tick = rtc_s2_r & ~rtc_s3_r;  // [RULE23]
  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // Shared free-running divider; stops in standby with the peripheral clock
  always @* begin
    presc_nxt = presc_r + 10'h001;
  end
  always @(posedge clk_sys) begin
    if (reset) begin
      presc_r <= 10'h000;
    end else if (clk_en && !standby) begin
      presc_r <= presc_nxt;
    end
  end
  // Terminal ticks of each divided clock
  wire tick4 = (presc_r[1:0] == 2'h3);
  wire tick16 = (presc_r[3:0] == 4'hF);
  wire tick64 = (presc_r[5:0] == 6'h3F);
  wire tick256 = (presc_r[7:0] == 8'hFF);
  wire tick1024 = (presc_r == 10'h3FF);
  // ----------------------------------------
  // Per-channel tick selection
  // ----------------------------------------
  wire [4:0] ch_tick;
  wire [4:0] ch_unf;
  wire [2:0] ch2_edge = channel_control_r[2][`DCT_BIT_EDGE_HI:`DCT_BIT_EDGE_LO] == 2'h0 ? 3'h1 :
                        channel_control_r[2][`DCT_BIT_EDGE_HI:`DCT_BIT_EDGE_LO] == 2'h1 ? 3'h2 : 3'h3;
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : gen_ch
      wire [2:0] ps = channel_control_r[g][2:0];
      wire [1:0] eg = channel_control_r[g][`DCT_BIT_EDGE_HI:`DCT_BIT_EDGE_LO];
      // Edge choice for pin counting: 00 rise, 01 fall, 1x both
      wire pin_evt = eg[1] ? (pin_rise | pin_fall) : (eg[0] ? pin_fall : pin_rise);  // [RULE10]
      reg sel;
      // RTC keeps ticking in standby on ch0-2; other sources freeze
      always @* begin
        case (ps)  // [RULE11]
          3'h0: sel = tick4 & ~standby;
          3'h1: sel = tick16 & ~standby;
          3'h2: sel = tick64 & ~standby;
          3'h3: sel = tick256 & ~standby;
          3'h4: sel = tick1024 & ~standby;
          `DCT_PS_RTC: sel = (g < 3) ? rtc_tick : 1'b0;  // [RULE13] [RULE12]
          `DCT_PS_EXT: sel = (g < 3) ? (pin_evt & ~standby) : 1'b0;  // [RULE12]
          default: sel = 1'b0;
        endcase
      end
      assign ch_tick[g] = sel & run_bits[g];  // [RULE16]
      assign ch_unf[g] = ch_tick[g] & (down_counter_r[g] == 32'h00000000);
    end
  endgenerate
  // ----------------------------------------
  // Capture event
  // ----------------------------------------
  // Capture works only with control 1x and never in standby
  wire cap_on = channel_control_r[2][`DCT_BIT_CAP_HI];  // [RULE8]
  wire cap_evt = cap_on & ~standby & |(ch2_edge & {1'b0, pin_fall, pin_rise});  // [RULE10]
  // ----------------------------------------
  // Register address decode
  // ----------------------------------------
  wire [7:0] wadr = {wb_adr_i[7:2], 2'b00};
  wire is_ctrl = (wadr >= `DCT_OFF_CTRL_BASE) && (wadr < `DCT_OFF_CTRL_BASE + 8'h14);
  wire is_const = (wadr >= `DCT_OFF_CONST_BASE) && (wadr < `DCT_OFF_CONST_BASE + 8'h14);
  wire is_count = (wadr >= `DCT_OFF_COUNT_BASE) && (wadr < `DCT_OFF_COUNT_BASE + 8'h14);
  wire [7:0] ci_w = (wadr - `DCT_OFF_CTRL_BASE) >> 2;
  wire [7:0] ki_w = (wadr - `DCT_OFF_CONST_BASE) >> 2;
  wire [7:0] ni_w = (wadr - `DCT_OFF_COUNT_BASE) >> 2;
  // Lane-merged 32-bit write data
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer b;
    begin
      for (b = 0; b < 4; b = b + 1)
        merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction
  // Writable mask per channel; flags handled separately
  function [7:0] ctl_mask;
    input integer ch;
    begin
      if (ch == 2) ctl_mask = 8'hFF;                       // [RULE2]
      else if (ch < 2) ctl_mask = 8'h3F;                   // [RULE2]
      else ctl_mask = 8'h27;                               // [RULE1]
    end
  endfunction
  // ----------------------------------------
  // Counters, constants, control
  // ----------------------------------------
  integer i;
  integer j; // Loop index owned by the interrupt process alone
  always @(posedge clk_sys) begin
    if (reset) begin
      for (i = 0; i < 5; i = i + 1) begin
        down_counter_r[i] <= `DCT_CNT_RESET;
        reload_constant_r[i] <= `DCT_CNT_RESET;
        channel_control_r[i] <= `DCT_CTRL_RESET;
      end
      start_register_low_r <= 3'h0;
      start_register_high_r <= 2'h0;
    end else if (clk_en) begin
      for (i = 0; i < 5; i = i + 1) begin
        // Counting, with reload on underflow
        if (ch_unf[i])
          down_counter_r[i] <= reload_constant_r[i];  // [RULE17] [RULE15]
        else if (ch_tick[i])
          down_counter_r[i] <= down_counter_r[i] - 32'h00000001;  // [RULE16]
        // Software write overrides the same cycle's count
        if (wr_req && is_count && ni_w == i)
          down_counter_r[i] <= merge(down_counter_r[i], wb_dat_i, wb_sel_i);  // [RULE24]
        if (wr_req && is_const && ki_w == i)
          reload_constant_r[i] <= merge(reload_constant_r[i], wb_dat_i, wb_sel_i);  // [RULE24]
        // Control fields; flags: zero clears, one keeps, set beats clear
        if (wr_req && is_ctrl && ci_w == i) begin
          // Low byte only with its lane; otherwise a flag clear would wipe setup
          if (wb_sel_i[0])
            channel_control_r[i][7:0] <= ctl_wdata[7:0] & ctl_mask(i);  // [RULE2]
          if (wb_sel_i[1] && !ctl_wdata[`DCT_BIT_UNF_FLAG])
            channel_control_r[i][`DCT_BIT_UNF_FLAG] <= 1'b0;  // [RULE4]
          if (i == 2 && wb_sel_i[1] && !ctl_wdata[`DCT_BIT_CAP_FLAG])
            channel_control_r[i][`DCT_BIT_CAP_FLAG] <= 1'b0;  // [RULE3]
        end
        if (ch_unf[i])
          channel_control_r[i][`DCT_BIT_UNF_FLAG] <= 1'b1;  // [RULE4] [RULE17]
        if (i == 2 && cap_evt)
          channel_control_r[i][`DCT_BIT_CAP_FLAG] <= 1'b1;  // [RULE3]
      end
      if (wr_req && wadr == `DCT_OFF_START_LO && wb_sel_i[0])
        start_register_low_r <= wb_dat_i[2:0];  // [RULE20]
      if (wr_req && wadr == `DCT_OFF_START_HI && wb_sel_i[0])
        start_register_high_r <= wb_dat_i[1:0];  // [RULE20]
    end
  end
  // ----------------------------------------
  // Capture register
  // ----------------------------------------
  // No reset branch: value is undefined until the first capture
  always @(posedge clk_sys) begin
    if (clk_en && cap_evt && !channel_control_r[2][`DCT_BIT_CAP_FLAG])
      capture_value_r <= down_counter_r[2];  // [RULE6] [RULE14]
  end
  // ----------------------------------------
  // DMA request and interrupts
  // ----------------------------------------
  // Request stays high until the DMA controller reports done
  always @(posedge clk_sys) begin
    if (reset) begin
      dma_busy_r <= 1'b0;
      capture_dma_req <= 1'b0;
      underflow_irq <= 5'h00;
      capture_irq <= 1'b0;
    end else if (clk_en) begin
      if (dma_busy_r && dma_done) begin
        dma_busy_r <= 1'b0;
        capture_dma_req <= 1'b0;
      end else if (!dma_busy_r && cap_evt) begin
        dma_busy_r <= 1'b1;        // [RULE5] [RULE7]
        capture_dma_req <= 1'b1;   // [RULE5]
      end
      for (j = 0; j < 5; j = j + 1)
        underflow_irq[j] <= channel_control_r[j][`DCT_BIT_UNF_FLAG] & channel_control_r[j][`DCT_BIT_UNF_IE];  // [RULE9]
      capture_irq <= channel_control_r[2][`DCT_BIT_CAP_FLAG] &
        (channel_control_r[2][`DCT_BIT_CAP_HI:`DCT_BIT_CAP_LO] == `DCT_CAP_IRQ_CODE);  // [RULE21] [RULE8]
    end
  end
  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  // One wait state; read data is the value before this edge's decrement
  always @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (clk_en) begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd_req) begin
        if (wadr == `DCT_OFF_START_LO)
          wb_dat_o <= {29'h0, start_register_low_r};
        else if (wadr == `DCT_OFF_START_HI)
          wb_dat_o <= {30'h0, start_register_high_r};
        else if (wadr == `DCT_OFF_CAPTURE)
          wb_dat_o <= capture_value_r;  // [RULE14]
        else if (is_ctrl)
          wb_dat_o <= {16'h0, channel_control_r[ci_w[2:0]]};  // [RULE1] [RULE2]
        else if (is_const)
          wb_dat_o <= reload_constant_r[ki_w[2:0]];
        else if (is_count)
          wb_dat_o <= down_counter_r[ni_w[2:0]];  // [RULE22]
        else
          wb_dat_o <= 32'h00000000;
      end
    end
  end
endmodule

/* dct_timer_assertions.sv */
// Purpose: port-level checks of bus, DMA and interrupt outputs
// Assumes: one clock, synchronous active-high reset
// Notes: bound into every timer instance
`timescale 1ns/1ps
module dct_timer_assertions (
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire standby,
  input wire dma_done,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [4:0] underflow_irq,
  input wire capture_irq,
  input wire capture_dma_req
);
  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  property p_ack_pulse;
    @(posedge clk_sys) disable iff (reset) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_answer;
    @(posedge clk_sys) disable iff (reset) wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing one cycle after request");
  property p_ack_cause;
    @(posedge clk_sys) disable iff (reset) $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // ----------------------------------------
  // DMA request and interrupt outputs
  // ----------------------------------------
  property p_dma_hold;
    @(posedge clk_sys) disable iff (reset) capture_dma_req && !dma_done |=> capture_dma_req;
  endproperty
  a_dma_hold: assert property (p_dma_hold) else $error("DMA request dropped early");
  property p_dma_release;
    @(posedge clk_sys) disable iff (reset) capture_dma_req && dma_done && clk_en |=> !capture_dma_req;
  endproperty
  a_dma_release: assert property (p_dma_release) else $error("DMA request kept after done");
  property p_dma_standby;
    @(posedge clk_sys) disable iff (reset) $rose(capture_dma_req) |-> !$past(standby);
  endproperty
  a_dma_standby: assert property (p_dma_standby) else $error("capture while in standby");
  // No disable here: the reset itself is the cause
  property p_out_reset;
    @(posedge clk_sys) reset && clk_en |=> underflow_irq == 5'h00 && !capture_irq && !capture_dma_req;
  endproperty
  a_out_reset: assert property (p_out_reset) else $error("outputs not cleared by reset");
  property p_freeze;
    @(posedge clk_sys) disable iff (reset) !clk_en |=> $stable(underflow_irq) && $stable(capture_dma_req);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule
bind dct_timer dct_timer_assertions dct_timer_assertions_i (.clk_sys(clk_sys), .reset(reset),
  .clk_en(clk_en), .standby(standby), .dma_done(dma_done), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .underflow_irq(underflow_irq), .capture_irq(capture_irq),
  .capture_dma_req(capture_dma_req));

/* dct_timer_tb_top.sv */
// Purpose: self-checking bench for the timer channels
// Assumes: Wishbone answer after one wait state
// Notes: pin edges give exact counts; prescale code 5 freezes channel 2
`timescale 1ns/1ps
module dct_timer_tb_top;
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg clk_en = 1'b1;
  reg timer_pin = 1'b0;
  reg slow = 1'b0;
  reg standby = 1'b0;
  reg rtc_clock = 1'b0;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire [4:0] underflow_irq;
  wire wb_ack_o, capture_irq, capture_dma_req, dma_done;
  integer errors = 0, num_checks = 0, dma_cnt = 0, i;
  reg dma_q = 1'b0;
  reg [31:0] q;
  reg [31:0] q1; // First sample of a rate measurement
  reg [71:0] rows [0:7]; // Address, write data, read-back
  always #10 clk_sys = ~clk_sys;
  dct_timer dct_timer_i (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .standby(standby),
    .timer_pin(timer_pin), .rtc_clock(rtc_clock), .dma_done(dma_done), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .underflow_irq(underflow_irq),
    .capture_irq(capture_irq), .capture_dma_req(capture_dma_req));
  dct_dma_model dct_dma_model_i (.clk_sys(clk_sys), .reset(reset),
    .capture_dma_req(capture_dma_req), .slow(slow), .dma_done(dma_done));
  // Count rising DMA requests
  always @(posedge clk_sys) begin
    dma_q <= capture_dma_req;
    if (capture_dma_req === 1'b1 && dma_q !== 1'b1) dma_cnt <= dma_cnt + 1;
  end
  task wrap_up;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  // One classic cycle; held until ack is sampled, data taken there
  task xfer(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && n < 50) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      if (n == 50) begin
        errors = errors + 1;
        $display("[ERR] %0t bus timeout", $time);
        wrap_up;
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      chk(q, e);
    end
  endtask
  // One rising edge on the RTC input
  task rtc_pulse;
    begin
      @(posedge clk_sys);
      rtc_clock <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rtc_clock <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask
  // One high pulse on the pin, long enough for the synchroniser
  // Pin is only ever driven towards the block, as an input
  task pulse;
    begin
      @(posedge clk_sys);
      timer_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      timer_pin <= 1'b0;
      repeat (8) @(posedge clk_sys);
    end
  endtask
  initial begin
    rows[0] = {8'h10, 32'h0000FFFF, 32'h0000003F};
    rows[1] = {8'h18, 32'h0000FCBF, 32'h000000BF};
    rows[2] = {8'h1C, 32'h0000FFFC, 32'h00000024}; // Divided clock only on ch3,4
    rows[3] = {8'h20, 32'h0000FFFC, 32'h00000024}; // Divided clock only on ch3,4
    rows[4] = {8'h34, 32'h12345678, 32'h12345678};
    rows[5] = {8'h00, 32'h000000F8, 32'h00000000};
    rows[6] = {8'h04, 32'h000000FC, 32'h00000000};
    rows[7] = {8'hFC, 32'hFFFFFFFF, 32'h00000000};
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h50, 32'hFFFFFFFF); // Counter reset
    rd(8'h30, 32'hFFFFFFFF); // Constant reset
    rd(8'h10, 32'h0); // Control reset
    for (i = 0; i < 8; i = i + 1) begin
      xfer(rows[i][71:64], 1'b1, rows[i][63:32]);
      rd(rows[i][71:64], rows[i][31:0]); // Masked read-back
    end
    $display("register table done");
    wb_sel_i <= 4'h2;
    xfer(8'h30, 1'b1, 32'hAABBCCDD); // Lane 1 only
    xfer(8'h10, 1'b1, 32'h00000000); // Low lane not selected
    wb_sel_i <= 4'hF;
    rd(8'h30, 32'hFFFFCCFF); // Lane merge
    rd(8'h10, 32'h0000003F); // Low byte untouched
    xfer(8'h18, 1'b1, 32'h0); // Capture off before pin
    // Channel 3 on divide-by-16: 64 cycles between taking edges give 4 ticks
    xfer(8'h1C, 1'b1, 32'h1); // Divide by 16
    xfer(8'h04, 1'b1, 32'h1); // Start ch3
    xfer(8'h5C, 1'b0, 32'h0);
    q1 = q;
    repeat (61) @(posedge clk_sys);
    rd(8'h5C, q1 - 32'h4); // Four ticks in 64 cycles
    $display("lanes and divider done");
    // Rising, falling, both edges on channel 0
    for (i = 0; i < 3; i = i + 1) begin
      xfer(8'h10, 1'b1, 32'h7 | (i << 3));
      xfer(8'h50, 1'b1, 32'hA);
      xfer(8'h00, 1'b1, 32'h1);
      pulse;
      rd(8'h50, (i == 2) ? 32'h8 : 32'h9); // Edge count
      xfer(8'h00, 1'b1, 32'h0);
    end
    $display("edge select done");
    xfer(8'h10, 1'b1, 32'h27);
    xfer(8'h30, 1'b1, 32'h5);
    xfer(8'h50, 1'b1, 32'h1);
    xfer(8'h00, 1'b1, 32'h1); // Start set last
    pulse;
    pulse;
    rd(8'h50, 32'h5); // Reloaded
    rd(8'h10, 32'h127); // Flag set
    @(posedge clk_sys);
    clk_en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    clk_en <= 1'b1;
    chk({27'h0, underflow_irq}, 32'h1); // Irq raised
    xfer(8'h10, 1'b1, 32'h107);
    rd(8'h10, 32'h107); // One keeps flag
    chk({27'h0, underflow_irq}, 32'h0); // Gated off
    xfer(8'h10, 1'b1, 32'h7);
    rd(8'h10, 32'h7); // Zero clears
    xfer(8'h00, 1'b1, 32'h0);
    pulse;
    rd(8'h50, 32'h5); // Stopped
    $display("underflow done");
    xfer(8'h18, 1'b1, 32'hC5);
    xfer(8'h58, 1'b1, 32'h55);
    pulse;
    rd(8'h08, 32'h55); // Captured
    rd(8'h18, 32'h2C5); // Capture flag
    chk({31'h0, capture_irq}, 32'h1); // Irq with 11
    chk(dma_cnt, 32'h1); // Request
    xfer(8'h58, 1'b1, 32'h66);
    pulse;
    rd(8'h08, 32'h55); // Kept while flag set
    chk(dma_cnt, 32'h2); // Request despite flag
    xfer(8'h18, 1'b1, 32'h2C5);
    rd(8'h18, 32'h2C5); // One keeps flag
    xfer(8'h18, 1'b1, 32'h85);
    pulse;
    rd(8'h08, 32'h66); // Fresh copy
    rd(8'h18, 32'h285); // Mode 10
    chk({31'h0, capture_irq}, 32'h0); // No irq with 10
    xfer(8'h18, 1'b1, 32'h5);
    pulse;
    chk(dma_cnt, 32'h3); // Off mode silent
    rd(8'h18, 32'h5); // Off mode silent
    slow <= 1'b1;
    xfer(8'h18, 1'b1, 32'h85);
    pulse;
    pulse;
    chk(dma_cnt, 32'h4); // Busy blocks second
    repeat (60) @(posedge clk_sys);
    chk({31'h0, capture_dma_req}, 32'h0); // Released
    $display("capture done");
    // Standby: RTC channel runs on, divided-clock channel and capture stop
    xfer(8'h10, 1'b1, 32'h0); // Ch0 on divide-by-4
    xfer(8'h14, 1'b1, 32'h6); // Ch1 on RTC
    xfer(8'h50, 1'b1, 32'h20);
    xfer(8'h54, 1'b1, 32'h20);
    standby <= 1'b1;
    xfer(8'h00, 1'b1, 32'h3); // Start set last
    repeat (4) rtc_pulse;
    pulse;
    rd(8'h54, 32'h1C); // RTC counts in standby
    rd(8'h50, 32'h20); // Divided clock frozen
    chk(dma_cnt, 32'h4); // No capture in standby
    standby <= 1'b0;
    xfer(8'h00, 1'b1, 32'h0);
    $display("standby done");
    // Mid-run reset: capture register keeps its value
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h08, 32'h66); // Not reset
    rd(8'h58, 32'hFFFFFFFF); // Counter reset
    rd(8'h18, 32'h0); // Control reset
    $display("second reset done");
    wrap_up;
  end
endmodule
